//--- dsoc_map.svh
// Offsets, field positions, reset values and counts of the deserializer output control
// Function
// R1: Recovered data leaves on a 21-bit parallel bus, bits 20..0, with a pixel clock.
// R2: Outputs launch against the pixel clock edge chosen by the clock edge select bit.
// R3: Serial control bus configuration works only while the configuration mode input is high.
// R4: While power-down input is low, outputs and link recovery stay inactive.
// R5: Entering power-down returns every programmed register to its default value.
// R6: Lock output high while recovery is locked; data and pixel clock then active.
// R7: Unlocked: lock low, output states follow the unlocked output state select bit.
// R8: The attached system may watch lock before trusting the parallel data.
// R9: Control bus target address comes from the address strap level.
// R10: Control bus clock is an input; data line is open drain, pulled up outside.
// R11: After power-down release, lock stays low until recovery has locked.
`ifndef DSOC_MAP_SVH
`define DSOC_MAP_SVH

// Register offsets on the serial control bus
`define DSOC_REG_CTRL       8'h00
`define DSOC_REG_STATUS     8'h01

// Field positions
`define DSOC_CTRL_EDGE_BIT  0
`define DSOC_CTRL_OSS_BIT   1
`define DSOC_STAT_LOCK_BIT  0
`define DSOC_STAT_MODE_BIT  1

// Reset values
`define DSOC_CTRL_RESET     8'h00
`define DSOC_ADDR_BASE      7'h30

// Link framing: start bit, 21 data bits, stop bit
`define DSOC_FRAME_BITS     23
`define DSOC_HALF_FRAME     12
`define DSOC_LOCK_FRAMES    4

`endif

//--- dsoc_pkg.sv
// Types shared by the deserializer output control files
`default_nettype none
package dsoc_pkg;

    typedef enum logic [2:0] {
        DSOC_IDLE,
        DSOC_RX,
        DSOC_ACK,
        DSOC_TX,
        DSOC_MACK
    } dsoc_bus_state_type;

    typedef struct packed {
        logic       strobe;
        logic [7:0] addr;
        logic [7:0] data;
    } dsoc_wr_type;

    typedef struct packed {
        logic oss_release;
        logic edge_falling;
    } dsoc_ctrl_type;

endpackage
`default_nettype wire

//--- dsoc_bus_target.sv
// Serial control bus target: addressing, pointer, byte writes and reads
`timescale 1ns/1ns
`default_nettype none
module dsoc_bus_target (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                clear,
    // Gating and address
    input  wire logic                enable,
    input  wire logic [6:0]          dev_addr,
    // Bus lines
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_drive_low,
    // Register side
    output dsoc_pkg::dsoc_wr_type    wr,
    output logic [7:0]               rd_addr,
    input  wire logic [7:0]          rd_data
);
    dsoc_pkg::dsoc_bus_state_type state_q;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [3:0] bit_q;
    logic [1:0] idx_q;
    logic       rw_q;
    logic [7:0] ptr_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;

    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start    = scl_in && scl_q && sda_q && !sda_in;
    assign stop     = scl_in && scl_q && !sda_q && sda_in;
    assign rd_addr  = ptr_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= dsoc_pkg::DSOC_IDLE;
            shift_q <= 8'h00;
            tx_q    <= 8'h00;
            bit_q   <= 4'h0;
            idx_q   <= 2'h0;
            rw_q    <= 1'b0;
            ptr_q   <= 8'h00;
            wr      <= '0;
        end else begin
            wr.strobe <= 1'b0;
            if (clear || !enable || stop) begin // R3 R5
                state_q <= dsoc_pkg::DSOC_IDLE;
                if (clear) begin
                    ptr_q <= 8'h00;
                end
            end else if (start) begin
                state_q <= dsoc_pkg::DSOC_RX;
                bit_q   <= 4'h0;
                idx_q   <= 2'h0;
            end else begin
                unique case (state_q)
                    dsoc_pkg::DSOC_IDLE: begin
                    end
                    dsoc_pkg::DSOC_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_in};
                            bit_q   <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (idx_q == 2'h0 && shift_q[7:1] != dev_addr) begin // R9
                                state_q <= dsoc_pkg::DSOC_IDLE;
                            end else begin
                                state_q <= dsoc_pkg::DSOC_ACK;
                                if (idx_q == 2'h0) begin
                                    rw_q <= shift_q[0];
                                end else if (idx_q == 2'h1) begin
                                    ptr_q <= shift_q;
                                end else begin
                                    wr.strobe <= 1'b1;
                                    wr.addr   <= ptr_q;
                                    wr.data   <= shift_q;
                                    ptr_q     <= ptr_q + 8'h01;
                                end
                            end
                        end
                    end
                    dsoc_pkg::DSOC_ACK: begin
                        if (scl_fall) begin
                            if (idx_q != 2'h2) begin
                                idx_q <= idx_q + 2'h1;
                            end
                            if (rw_q) begin
                                state_q <= dsoc_pkg::DSOC_TX;
                                tx_q    <= rd_data;
                                ptr_q   <= ptr_q + 8'h01;
                            end else begin
                                state_q <= dsoc_pkg::DSOC_RX;
                            end
                        end
                    end
                    dsoc_pkg::DSOC_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h7) begin
                                bit_q   <= 4'h0;
                                state_q <= dsoc_pkg::DSOC_MACK;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                                tx_q  <= {tx_q[6:0], 1'b0};
                            end
                        end
                    end
                    dsoc_pkg::DSOC_MACK: begin
                        if (scl_rise && sda_in) begin
                            state_q <= dsoc_pkg::DSOC_IDLE;
                        end else if (scl_fall) begin
                            state_q <= dsoc_pkg::DSOC_TX;
                            tx_q    <= rd_data;
                            ptr_q   <= ptr_q + 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    always_comb begin
        sda_drive_low = 1'b0; // R10
        if (state_q == dsoc_pkg::DSOC_ACK) begin
            sda_drive_low = 1'b1;
        end else if (state_q == dsoc_pkg::DSOC_TX) begin
            sda_drive_low = !tx_q[7];
        end
    end
endmodule
`default_nettype wire

//--- dsoc_top.sv
// Deserializer output side: link lock, parallel outputs, pixel clock, control registers
`timescale 1ns/1ns
`default_nettype none
`include "dsoc_map.svh"
module dsoc_top #(
    parameter int DATA_W      = 21,
    parameter int FRAME_BITS  = `DSOC_FRAME_BITS,
    parameter int HALF_FRAME  = `DSOC_HALF_FRAME,
    parameter int LOCK_FRAMES = `DSOC_LOCK_FRAMES,
    parameter int STRAP_W     = 3
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // Control pins
    input  wire logic               power_down_n,
    input  wire logic               config_mode,
    input  wire logic [STRAP_W-1:0] address_strap_input,
    // Serial link
    input  wire logic               serial_in_pos,
    input  wire logic               serial_in_neg,
    // Serial control bus
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    // Parallel output side
    output logic [DATA_W-1:0]       parallel_data_out,
    output logic                    pixel_clock_out,
    output logic                    outputs_enable,
    output logic                    lock_status
);
    localparam int CNT_W  = $clog2(FRAME_BITS);
    localparam int GOOD_W = $clog2(LOCK_FRAMES + 1);
    localparam logic [CNT_W-1:0]  LAST_CNT = CNT_W'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0]  HALF_CNT = CNT_W'(HALF_FRAME);
    localparam logic [GOOD_W-1:0] GOOD_MAX = GOOD_W'(LOCK_FRAMES);

    dsoc_pkg::dsoc_ctrl_type ctrl_q;
    dsoc_pkg::dsoc_wr_type   wr;
    logic [7:0]              rd_addr;
    logic [7:0]              rd_data;
    logic                    sda_drive_low;
    logic                    pd_n_q;
    logic [6:0]              dev_addr_q;
    logic [CNT_W-1:0]        cnt_q;
    logic [FRAME_BITS-2:0]   shift_q;
    logic                    line_err_q;
    logic [GOOD_W-1:0]       good_q;
    logic                    locked_q;
    logic [DATA_W-1:0]       word_q;
    logic [FRAME_BITS-1:0]   frame;
    logic                    frame_end;
    logic                    frame_ok;
    logic                    pd_entry;
    logic                    launch;

    assign frame     = {shift_q, serial_in_pos};
    assign frame_end = (cnt_q == LAST_CNT);
    assign frame_ok  = frame[FRAME_BITS-1] && !frame[0] && !line_err_q
                       && (serial_in_pos != serial_in_neg);
    assign pd_entry  = !power_down_n;
    // Strobe on rising: launch at the falling edge, and the reverse
    assign launch    = ctrl_q.edge_falling ? (cnt_q == '0) : (cnt_q == HALF_CNT); // R2

    // Power-down level tracking and strap capture after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pd_n_q     <= 1'b0;
            dev_addr_q <= `DSOC_ADDR_BASE;
        end else begin
            pd_n_q <= power_down_n;
            if (power_down_n && !pd_n_q) begin
                dev_addr_q <= `DSOC_ADDR_BASE + 7'(address_strap_input); // R9
            end
        end
    end

    dsoc_bus_target u_bus (
        .clk           (clk),
        .resetn        (resetn),
        .clear         (pd_entry),
        .enable        (config_mode),
        .dev_addr      (dev_addr_q),
        .scl_in        (scl_in),
        .sda_in        (sda_in),
        .sda_drive_low (sda_drive_low),
        .wr            (wr),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data)
    );

    // Control register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= dsoc_pkg::dsoc_ctrl_type'(2'(`DSOC_CTRL_RESET));
        end else if (pd_entry) begin
            ctrl_q <= dsoc_pkg::dsoc_ctrl_type'(2'(`DSOC_CTRL_RESET)); // R5
        end else if (wr.strobe && wr.addr == `DSOC_REG_CTRL && config_mode) begin // R3
            ctrl_q.edge_falling <= wr.data[`DSOC_CTRL_EDGE_BIT];
            ctrl_q.oss_release  <= wr.data[`DSOC_CTRL_OSS_BIT];
        end
    end

    // Read mux; unmapped offsets read as zero
    always_comb begin
        rd_data = 8'h00;
        unique case (rd_addr)
            `DSOC_REG_CTRL: begin
                rd_data[`DSOC_CTRL_EDGE_BIT] = ctrl_q.edge_falling;
                rd_data[`DSOC_CTRL_OSS_BIT]  = ctrl_q.oss_release;
            end
            `DSOC_REG_STATUS: begin
                rd_data[`DSOC_STAT_LOCK_BIT] = locked_q;
                rd_data[`DSOC_STAT_MODE_BIT] = config_mode;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // Open drain data line
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sda_out <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            sda_oe  <= sda_drive_low; // R10
        end
    end

    // Frame bit counter; a bad frame while hunting slips one bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (pd_entry) begin
            cnt_q <= '0; // R4
        end else if (frame_end) begin
            cnt_q <= '0;
        end else if (cnt_q == '0 && !locked_q && good_q == '0 && line_err_q) begin
            cnt_q <= cnt_q;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // Serial shift and line fault within the frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q    <= '0;
            line_err_q <= 1'b0;
        end else if (pd_entry) begin
            shift_q    <= '0; // R4
            line_err_q <= 1'b0;
        end else begin
            shift_q <= {shift_q[FRAME_BITS-3:0], serial_in_pos};
            if (frame_end) begin
                line_err_q <= !frame_ok && (good_q == '0) && !locked_q;
            end else if (serial_in_pos == serial_in_neg) begin
                line_err_q <= 1'b1;
            end else if (cnt_q == '0) begin
                // Slip lasts one cycle; a stuck flag would park the counter
                line_err_q <= 1'b0;
            end
        end
    end

    // Lock acquisition: enough good frames in a row, lost on any bad frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            good_q   <= '0;
            locked_q <= 1'b0;
        end else if (pd_entry) begin
            good_q   <= '0; // R4 R11
            locked_q <= 1'b0;
        end else if (frame_end) begin
            if (frame_ok) begin
                if (good_q != GOOD_MAX) begin
                    good_q <= good_q + GOOD_W'(1);
                end
                if (good_q + GOOD_W'(1) >= GOOD_MAX) begin
                    locked_q <= 1'b1; // R11
                end
            end else begin
                good_q   <= '0;
                locked_q <= 1'b0; // R7
            end
        end
    end

    // Recovered word
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            word_q <= '0;
        end else if (pd_entry) begin
            word_q <= '0;
        end else if (frame_end && frame_ok) begin
            word_q <= frame[FRAME_BITS-2:1]; // R1
        end
    end

    // Lock output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_status <= 1'b0;
        end else begin
            lock_status <= locked_q && !pd_entry; // R6 R7 R11
        end
    end

    // Pixel clock: high for the first half of each frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pixel_clock_out <= 1'b0;
        end else if (pd_entry || !locked_q) begin
            pixel_clock_out <= 1'b0; // R4 R7
        end else begin
            pixel_clock_out <= (cnt_q < HALF_CNT); // R1 R6
        end
    end

    // Parallel data launched at the edge opposite the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            parallel_data_out <= '0;
        end else if (pd_entry || !locked_q) begin
            parallel_data_out <= '0; // R4 R7
        end else if (launch) begin
            parallel_data_out <= word_q; // R1 R2 R6
        end
    end

    // Output drivers: off in power-down, per select while unlocked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outputs_enable <= 1'b0;
        end else if (pd_entry) begin
            outputs_enable <= 1'b0; // R4
        end else if (!locked_q) begin
            outputs_enable <= !ctrl_q.oss_release; // R7
        end else begin
            outputs_enable <= 1'b1; // R6
        end
    end
endmodule
`default_nettype wire

//--- dsoc_top_monitor.sv
// Port checker for the deserializer output control block
`timescale 1ns/1ns
`default_nettype none
module dsoc_top_monitor #(
    parameter int DATA_W  = 21,
    parameter int STRAP_W = 3
) (
    // Clock and reset
    input wire logic               clk,
    input wire logic               resetn,
    // Control pins
    input wire logic               power_down_n,
    input wire logic               config_mode,
    input wire logic [STRAP_W-1:0] address_strap_input,
    // Serial link
    input wire logic               serial_in_pos,
    input wire logic               serial_in_neg,
    // Serial control bus
    input wire logic               scl_in,
    input wire logic               sda_in,
    input wire logic               sda_out,
    input wire logic               sda_oe,
    // Parallel output side
    input wire logic [DATA_W-1:0]  parallel_data_out,
    input wire logic               pixel_clock_out,
    input wire logic               outputs_enable,
    input wire logic               lock_status
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_pd_outputs_off: assert property (!power_down_n [*2] |-> !lock_status && !outputs_enable
        && parallel_data_out == '0 && !pixel_clock_out && !sda_oe)
        else $error("outputs active during power-down");
    a_unlock_quiet: assert property (!lock_status [*2] |->
        parallel_data_out == '0 && !pixel_clock_out)
        else $error("data or pixel clock active while unlocked");
    a_lock_enable: assert property (lock_status [*2] |-> outputs_enable)
        else $error("outputs disabled while locked");
    a_lock_after_pd: assert property ($rose(power_down_n) |-> !lock_status [*8])
        else $error("lock high too soon after power-down release");
    a_sda_low_only: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    a_mode_gate: assert property (!config_mode [*3] |-> !sda_oe)
        else $error("bus answered with configuration mode low");
    a_pclk_high: assert property (disable iff (!resetn || !lock_status)
        $rose(pixel_clock_out) && $past(lock_status) |->
        pixel_clock_out [*8] ##1 pixel_clock_out [*4] ##1 !pixel_clock_out)
        else $error("pixel clock high phase not twelve cycles");
    a_data_on_edge: assert property (lock_status && $past(lock_status)
        && $changed(parallel_data_out) |-> $changed(pixel_clock_out))
        else $error("data changed away from a pixel clock edge");

    c_lock: cover property ($rose(lock_status));
    c_ack: cover property ($rose(sda_oe));
    c_unlock: cover property ($fell(lock_status));
endmodule
`default_nettype wire

//--- dsoc_link_model.sv
// Serial link source feeding framed words into the deserializer
`timescale 1ns/1ns
`default_nettype none
module dsoc_link_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Bench control
    input  wire logic        run,
    input  wire logic        fault,
    input  wire logic [20:0] word,
    // Serial link
    output logic             serial_in_pos,
    output logic             serial_in_neg
);
    logic [4:0]  cnt_q;
    logic [20:0] word_q;
    logic        bit_d;
    logic        pos_d;

    // Start bit, data MSB first, stop bit
    always_comb begin
        if (cnt_q == 5'h00) begin
            bit_d = 1'b1;
        end else if (cnt_q == 5'h16) begin
            bit_d = 1'b0;
        end else begin
            bit_d = word_q[5'h15 - cnt_q];
        end
        pos_d = run ? bit_d : ~serial_in_pos;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 5'h00;
            word_q <= 21'h000000;
        end else if (!run || cnt_q == 5'h16) begin
            cnt_q <= 5'h00;
            word_q <= word;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Fault makes both legs equal
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            serial_in_pos <= 1'b0;
            serial_in_neg <= 1'b1;
        end else begin
            serial_in_pos <= pos_d;
            serial_in_neg <= fault ? pos_d : ~pos_d;
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// Testbench for the deserializer output control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int LF = 2;
    logic        clk, resetn, power_down_n, config_mode, scl_in, sda_m, run, fault;
    logic [2:0]  strap;
    logic [20:0] word, parallel_data_out;
    logic        serial_in_pos, serial_in_neg, sda_out, sda_oe, sda_w;
    logic        pixel_clock_out, outputs_enable, lock_status, ack;
    logic [7:0]  rd;
    int          error_cnt, checks, n;

    // Open-drain data line, pulled up
    assign sda_w = sda_m & ~(sda_oe & ~sda_out);

    dsoc_top #(.LOCK_FRAMES(LF)) dsoc_top_i (.clk(clk), .resetn(resetn),
        .power_down_n(power_down_n), .config_mode(config_mode), .address_strap_input(strap),
        .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg), .scl_in(scl_in),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .parallel_data_out(parallel_data_out), .pixel_clock_out(pixel_clock_out),
        .outputs_enable(outputs_enable), .lock_status(lock_status));
    dsoc_link_model dsoc_link_model_i (.clk(clk), .resetn(resetn), .run(run), .fault(fault),
        .word(word), .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wait_lock(input logic v);
        n = 0;
        while (lock_status !== v) begin
            tick(1);
            n++;
            if (n > 3000) begin
                chk("lock wait", 32'(v), 32'(lock_status));
                close_out();
            end
        end
    endtask

    task automatic bit_io(input logic b, output logic s);
        sda_m <= b;
        tick(3);
        scl_in <= 1'b1;
        tick(4);
        s = sda_w;
        scl_in <= 1'b0;
        tick(3);
    endtask

    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(1'b1, a);
    endtask

    task automatic bus_start();
        sda_m <= 1'b1;
        scl_in <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
        scl_in <= 1'b0;
        tick(2);
    endtask

    // Write pointer then one data byte, or pointer then one read byte
    task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic rdn,
                        input logic [7:0] wd);
        logic       a2;
        logic [7:0] dummy;
        bus_start();
        byte_io({a, 1'b0}, dummy, ack);
        byte_io(p, dummy, a2);
        if (rdn) begin
            bus_start();
            byte_io({a, 1'b1}, dummy, a2);
            byte_io(8'hff, rd, a2);
        end else begin
            byte_io(wd, dummy, a2);
        end
        sda_m <= 1'b0;
        tick(3);
        scl_in <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(4);
    endtask

    // Pixel clock level in the cycle where a new word first shows
    task automatic edge_chk(input logic [20:0] w, input logic pc);
        logic hit;
        hit = 1'b0;
        word <= w;
        for (int k = 0; k < 300 && !hit; k++) begin
            @(posedge clk);
            #1;
            if (parallel_data_out === w) begin
                hit = 1'b1;
                chk("pclk at data change", 32'(pc), 32'(pixel_clock_out));
            end
        end
        chk("data word", 32'(w), 32'(parallel_data_out));
        tick(1);
    endtask

    initial begin
        error_cnt = 0;
        checks = 0;
        resetn = 1'b0;
        power_down_n = 1'b0;
        config_mode = 1'b1;
        scl_in = 1'b1;
        sda_m = 1'b1;
        run = 1'b0;
        fault = 1'b0;
        strap = 3'h5;
        // Ones then zeros: only the true alignment shows start and stop
        word = 21'h1c0000;
        tick(6);
        resetn <= 1'b1;
        tick(2);
        chk("pd lock", 32'h0, 32'(lock_status));
        chk("pd data", 32'h0, 32'(parallel_data_out));
        chk("pd enable", 32'h0, 32'(outputs_enable));
        power_down_n <= 1'b1;
        run <= 1'b1;
        wait_lock(1'b1);
        chk("lock delay", 32'h1, 32'(n > (LF - 1) * 23));
        edge_chk(21'h0f0f0f, 1'b0);
        chk("enable locked", 32'h1, 32'(outputs_enable));
        xfer(7'h35, 8'h00, 1'b0, 8'h01);
        chk("ack strap", 32'h0, 32'(ack));
        edge_chk(21'h12345a, 1'b1);
        xfer(7'h35, 8'h00, 1'b1, 8'h00);
        chk("ctrl read", 32'h01, 32'(rd));
        xfer(7'h35, 8'h01, 1'b1, 8'h00);
        chk("status read", 32'h03, 32'(rd));
        xfer(7'h34, 8'h00, 1'b0, 8'h02);
        chk("ack other", 32'h1, 32'(ack));
        config_mode <= 1'b0;
        xfer(7'h35, 8'h00, 1'b0, 8'h02);
        chk("ack no mode", 32'h1, 32'(ack));
        config_mode <= 1'b1;
        xfer(7'h35, 8'h00, 1'b0, 8'h03);
        fault <= 1'b1;
        wait_lock(1'b0);
        tick(3);
        chk("unlocked data", 32'h0, 32'(parallel_data_out));
        chk("unlocked pclk", 32'h0, 32'(pixel_clock_out));
        chk("released enable", 32'h0, 32'(outputs_enable));
        xfer(7'h35, 8'h00, 1'b0, 8'h01);
        chk("driven enable", 32'h1, 32'(outputs_enable));
        fault <= 1'b0;
        wait_lock(1'b1);
        power_down_n <= 1'b0;
        tick(3);
        chk("pd relock", 32'h0, 32'(lock_status));
        power_down_n <= 1'b1;
        tick(3);
        xfer(7'h35, 8'h00, 1'b1, 8'h00);
        chk("ctrl default", 32'h00, 32'(rd));
        close_out();
    end
endmodule

bind dsoc_top dsoc_top_monitor #(.DATA_W(DATA_W), .STRAP_W(STRAP_W)) dsoc_top_monitor_i (
    .clk(clk), .resetn(resetn), .power_down_n(power_down_n), .config_mode(config_mode),
    .address_strap_input(address_strap_input), .serial_in_pos(serial_in_pos),
    .serial_in_neg(serial_in_neg), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .parallel_data_out(parallel_data_out),
    .pixel_clock_out(pixel_clock_out), .outputs_enable(outputs_enable),
    .lock_status(lock_status));
`default_nettype wire
